// *** logic/sic_pkg.sv ***
// Purpose: shared constants and types for the software interrupt clear block
// Assumes: 8-bit interrupt registers mapped on a 32-bit Avalon-MM word bus
// Notes:   register indices are kept as printed; byte address is four times index
package sic_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] SIC_IDX_RAW   = 8'hfb;  // raw status, read only
    localparam logic [7:0] SIC_IDX_STAT  = 8'hfc;  // masked status, read only
    localparam logic [7:0] SIC_IDX_MASK  = 8'hfd;  // enable mask, read/write
    localparam logic [7:0] SIC_IDX_ACK   = 8'hff;  // interrupt_acknowledge, write only
    localparam int         SIC_ADDR_W    = 10;     // byte address width

    // ****************************************
    // field layout
    // ****************************************
    localparam int         SIC_BIT_ARXC  = 5;      // antenna_rx_complete
    localparam int         SIC_BIT_ATXC  = 4;      // antenna_tx_complete
    localparam int         SIC_BIT_ARXT  = 3;      // antenna_rx_timeout
    localparam int         SIC_BIT_TERR  = 1;      // tuner_xfer_error
    localparam int         SIC_BIT_TDONE = 0;      // tuner_xfer_done
    localparam logic [7:0] SIC_IMPL_MASK = 8'h3b;  // implemented source bits
    localparam logic [7:0] SIC_RST_VAL   = 8'h00;  // reset value of all registers

    // five event sources as a packed group
    typedef struct packed {
        logic antennaRxComplete;
        logic antennaTxComplete;
        logic antennaRxTimeout;
        logic tunerXferError;
        logic tunerXferDone;
    } sic_events_t;

    // avalon slave request bundle
    typedef struct packed {
        logic [SIC_ADDR_W-1:0] address;
        logic                  read;
        logic                  write;
        logic [3:0]            byteenable;
        logic [31:0]           writedata;
    } sic_req_t;

endpackage

// *** logic/sic_interrupt_clear.sv ***
// Purpose: interrupt status, mask and write-one-to-clear acknowledge logic
// Assumes: event pulses and bus signals are synchronous to clk_sys
// Notes:   writes take no wait state, reads one so that read data leaves a flip-flop;
//          unmapped and acknowledge reads return zero
//
// Summary of operation
// - writing a one to a source bit of the acknowledge register clears that raw status bit.
// - clearing a raw bit also clears its masked status bit and its interrupt contribution.
// - acknowledge bits are never stored, acting as one-cycle clear pulses that read back zero.
// - the interrupt request falls once no unmasked source is pending.
// - acknowledge bit 5 clears the antenna receive-complete event.
// - acknowledge bit 4 clears the antenna transmit-complete event.
// - acknowledge bit 3 clears the antenna receive-timeout event.
// - acknowledge bit 1 clears the tuner transaction-error event.
// - acknowledge bit 0 clears the tuner transaction-done event.
// - acknowledge bits 7, 6 and 2 are reserved and writes to them do nothing.
// - a masked source still sets its raw bit but not its status bit nor the request.
// - every mask bit resets to zero, disabling its source, and a one enables it.
// - the receive-timeout event is raised by the antenna logic after its timeout period.
// - the tuner raises error on no response or a refused acknowledge, otherwise done.
//
// The Avalon-MM slave port is this design's own decision.
module sic_interrupt_clear
(
    input  wire logic                      clk_sys,
    input  wire logic                      reset,
    input  wire sic_pkg::sic_events_t      events,
    input  wire sic_pkg::sic_req_t         avsReq,
    output logic      [31:0]               avsReaddata,
    output logic                           avsWaitrequest,
    output logic                           irqOut
);

    // ****************************************
    // decode helpers
    // ****************************************

    // word index match, used for every register
    function automatic logic hitIndex
    (
        input logic [sic_pkg::SIC_ADDR_W-1:0] addr,
        input logic [7:0]                     idx
    );
        hitIndex = (addr[sic_pkg::SIC_ADDR_W-1:2] == idx) && (addr[1:0] == 2'h0);
    endfunction

    // ****************************************
    // storage
    // ****************************************
    logic [7:0] rawReg;
    logic [7:0] rawNext;
    logic [7:0] maskReg;
    logic [7:0] eventBits;
    logic [7:0] ackPulse;
    logic [7:0] statusBits;
    logic       lowLane;
    logic       writeAck;
    logic       writeMask;
    logic       rdPhaseReg;
    logic [7:0] rdSelect;

    // reads stall one cycle while the word is loaded into the read flip-flops;
    // writes never wait, since nothing has to be fetched before they land
    assign avsWaitrequest = avsReq.read && !rdPhaseReg;

    assign lowLane   = avsReq.byteenable[0];
    assign writeAck  = avsReq.write && lowLane && hitIndex(avsReq.address, sic_pkg::SIC_IDX_ACK);
    assign writeMask = avsReq.write && lowLane && hitIndex(avsReq.address, sic_pkg::SIC_IDX_MASK);

    // place the event pulses at their documented positions, reserved lanes stay zero
    always_comb
    begin
        eventBits                          = 8'h00;
        eventBits[sic_pkg::SIC_BIT_ARXC]   = events.antennaRxComplete;
        eventBits[sic_pkg::SIC_BIT_ATXC]   = events.antennaTxComplete;
        eventBits[sic_pkg::SIC_BIT_ARXT]   = events.antennaRxTimeout;
        eventBits[sic_pkg::SIC_BIT_TERR]   = events.tunerXferError;
        eventBits[sic_pkg::SIC_BIT_TDONE]  = events.tunerXferDone;
    end

    // acknowledge is a combinational pulse only; nothing holds it, so it is zero next cycle
    // reserved bits are stripped by the implemented-bit mask
    assign ackPulse = writeAck ? (avsReq.writedata[7:0] & sic_pkg::SIC_IMPL_MASK)
                               : 8'h00;

    // ****************************************
    // raw status: set wins over clear
    // ****************************************
    always_comb
    begin
        rawNext = ((rawReg & ~ackPulse) | eventBits) & sic_pkg::SIC_IMPL_MASK;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            rawReg <= sic_pkg::SIC_RST_VAL;
        else
            rawReg <= rawNext;
    end

    // ****************************************
    // mask register
    // ****************************************
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            maskReg <= sic_pkg::SIC_RST_VAL;
        else if (writeMask)
            maskReg <= avsReq.writedata[7:0] & sic_pkg::SIC_IMPL_MASK;
    end

    // masked status follows raw, so clearing raw clears status in the same edge
    assign statusBits = rawReg & maskReg;

    // ****************************************
    // interrupt request
    // ****************************************
    // registered from rawNext so the pin is glitch free; moves with status, one cycle late only after a mask write
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            irqOut <= 1'b0;
        else
            irqOut <= |(rawNext & maskReg);
    end

    // ****************************************
    // read data
    // ****************************************
    // select the addressed register; acknowledge and unmapped words give zero
    always_comb
    begin
        rdSelect = 8'h00;
        if (hitIndex(avsReq.address, sic_pkg::SIC_IDX_RAW))
            rdSelect = rawReg;
        else if (hitIndex(avsReq.address, sic_pkg::SIC_IDX_STAT))
            rdSelect = statusBits;
        else if (hitIndex(avsReq.address, sic_pkg::SIC_IDX_MASK))
            rdSelect = maskReg;
        // acknowledge reads as zero: its bits are never stored
    end

    // first read cycle loads the word and stalls, the second one releases it
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            rdPhaseReg <= 1'b0;
        else
            rdPhaseReg <= avsReq.read && !rdPhaseReg;
    end

    // the loaded word stands through the accepting edge and drops to zero after;
    // costs one cycle per read but keeps the bus data free of decode glitches
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            avsReaddata <= 32'h0000_0000;
        else if (avsReq.read && !rdPhaseReg)
            avsReaddata <= {24'h00_0000, rdSelect};
        else if (!avsReq.read)
            avsReaddata <= 32'h0000_0000;
    end

    // ****************************************
    // checks
    // ****************************************
    ack_clears_raw_a: assert property (@(posedge clk_sys) disable iff (reset)
        (writeAck && avsReq.writedata[sic_pkg::SIC_BIT_TERR] && !eventBits[sic_pkg::SIC_BIT_TERR])
        |=> !rawReg[sic_pkg::SIC_BIT_TERR])
        else $error("acknowledge did not clear raw bit");

    status_follows_raw_a: assert property (@(posedge clk_sys) disable iff (reset)
        $fell(rawReg[sic_pkg::SIC_BIT_ARXC]) |-> !statusBits[sic_pkg::SIC_BIT_ARXC])
        else $error("status bit outlived raw bit");

    ack_reads_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
        (avsReq.read && !avsWaitrequest && hitIndex(avsReq.address, sic_pkg::SIC_IDX_ACK))
        |-> avsReaddata == 32'h0)
        else $error("acknowledge register read non-zero");

    irq_tracks_pending_a: assert property (@(posedge clk_sys) disable iff (reset)
        ##1 (irqOut == |$past(rawNext & maskReg)))
        else $error("interrupt request disagrees with pending sources");

    timeout_bit_pos_a: assert property (@(posedge clk_sys) disable iff (reset)
        events.antennaRxTimeout |=> rawReg[3])
        else $error("receive timeout not at bit 3");

    done_bit_pos_a: assert property (@(posedge clk_sys) disable iff (reset)
        events.tunerXferDone |=> rawReg[0])
        else $error("transfer done not at bit 0");

    reserved_quiet_a: assert property (@(posedge clk_sys) disable iff (reset)
        1'b1 |-> (rawReg[7:6] == 2'h0) && !rawReg[2] && (maskReg & ~sic_pkg::SIC_IMPL_MASK) == 8'h0)
        else $error("reserved bit became set");

    masked_no_irq_a: assert property (@(posedge clk_sys) disable iff (reset)
        (maskReg == 8'h00) [*2] |-> !irqOut)
        else $error("masked source raised interrupt");

    set_beats_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
        (ackPulse[sic_pkg::SIC_BIT_ATXC] && events.antennaTxComplete)
        |=> rawReg[sic_pkg::SIC_BIT_ATXC])
        else $error("event lost to simultaneous clear");

    mask_reset_a: assert property (@(posedge clk_sys)
        reset |=> maskReg == 8'h00)
        else $error("mask not zero after reset");

    // ****************************************
    // bit positions of the remaining sources
    // ****************************************
    rx_complete_pos_a: assert property (@(posedge clk_sys) disable iff (reset)
        events.antennaRxComplete |=> rawReg[5])
        else $error("receive complete not at bit 5");

    tx_complete_pos_a: assert property (@(posedge clk_sys) disable iff (reset)
        events.antennaTxComplete |=> rawReg[4])
        else $error("transmit complete not at bit 4");

    error_bit_pos_a: assert property (@(posedge clk_sys) disable iff (reset)
        events.tunerXferError |=> rawReg[1])
        else $error("transfer error not at bit 1");

    // ****************************************
    // acknowledge pulse behaviour
    // ****************************************
    // a pulse outside a write would clear sources nobody acknowledged
    ack_is_pulse_a: assert property (@(posedge clk_sys) disable iff (reset)
        !writeAck |-> ackPulse == 8'h00)
        else $error("acknowledge pulse without a write");

    ack_reserved_a: assert property (@(posedge clk_sys) disable iff (reset)
        (ackPulse & ~sic_pkg::SIC_IMPL_MASK) == 8'h00)
        else $error("reserved acknowledge bit reached the sources");

    // without event or acknowledge the raw word must not drift
    raw_holds_a: assert property (@(posedge clk_sys) disable iff (reset)
        (ackPulse == 8'h00 && eventBits == 8'h00) |=> $stable(rawReg))
        else $error("raw status changed without cause");

    // ****************************************
    // mask and interrupt request
    // ****************************************
    mask_write_a: assert property (@(posedge clk_sys) disable iff (reset)
        writeMask |=> maskReg == $past(avsReq.writedata[7:0] & sic_pkg::SIC_IMPL_MASK))
        else $error("mask write did not land");

    mask_holds_a: assert property (@(posedge clk_sys) disable iff (reset)
        !writeMask |=> $stable(maskReg))
        else $error("mask changed without a write");

    // a masked event must still be recorded, but only in the raw word
    masked_raw_sets_a: assert property (@(posedge clk_sys) disable iff (reset)
        (eventBits[sic_pkg::SIC_BIT_ARXC] && !maskReg[sic_pkg::SIC_BIT_ARXC] && !writeMask)
        |=> rawReg[sic_pkg::SIC_BIT_ARXC] && !statusBits[sic_pkg::SIC_BIT_ARXC])
        else $error("masked event handled wrongly");

    irq_falls_a: assert property (@(posedge clk_sys) disable iff (reset)
        (statusBits == 8'h00 && (eventBits & maskReg) == 8'h00) |=> !irqOut)
        else $error("interrupt request stayed with nothing pending");

    irq_rises_a: assert property (@(posedge clk_sys) disable iff (reset)
        (|(rawNext & maskReg)) |=> irqOut)
        else $error("interrupt request missing for pending source");

    irq_reset_a: assert property (@(posedge clk_sys)
        reset |=> !irqOut)
        else $error("interrupt request high after reset");

    // ****************************************
    // register bus
    // ****************************************
    // a read stalls exactly once, a write never
    rd_wait_once_a: assert property (@(posedge clk_sys) disable iff (reset)
        (avsReq.read && avsWaitrequest) |=> !avsWaitrequest)
        else $error("read stalled more than one cycle");

    wr_no_wait_a: assert property (@(posedge clk_sys) disable iff (reset)
        avsReq.write |-> !avsWaitrequest)
        else $error("write was stalled");

    // the word handed over is the one loaded at the stalling edge
    raw_readback_a: assert property (@(posedge clk_sys) disable iff (reset)
        (avsReq.read && !avsWaitrequest && hitIndex(avsReq.address, sic_pkg::SIC_IDX_RAW))
        |-> avsReaddata == {24'h00_0000, $past(rawReg)})
        else $error("raw status read back wrong");

    stat_readback_a: assert property (@(posedge clk_sys) disable iff (reset)
        (avsReq.read && !avsWaitrequest && hitIndex(avsReq.address, sic_pkg::SIC_IDX_STAT))
        |-> avsReaddata == {24'h00_0000, $past(statusBits)})
        else $error("status read back wrong");

    mask_readback_a: assert property (@(posedge clk_sys) disable iff (reset)
        (avsReq.read && !avsWaitrequest && hitIndex(avsReq.address, sic_pkg::SIC_IDX_MASK))
        |-> avsReaddata == {24'h00_0000, $past(maskReg)})
        else $error("mask read back wrong");

    // read data must not linger once the master lets go
    rd_idle_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
        !avsReq.read |=> avsReaddata == 32'h0)
        else $error("read data lingered after the read");

    // ****************************************
    // per-bit checks
    // ****************************************
    // live bits must follow set-wins-over-clear, reserved bits must stay zero
    generate
        for (genvar g = 0; g < 8; g++)
        begin : gBit
            if (sic_pkg::SIC_IMPL_MASK[g])
            begin : gLive
                src_set_a: assert property (@(posedge clk_sys) disable iff (reset)
                    eventBits[g] |=> rawReg[g])
                    else $error("event did not set its raw bit");

                src_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
                    (ackPulse[g] && !eventBits[g]) |=> !rawReg[g])
                    else $error("acknowledge did not clear its raw bit");

                src_status_a: assert property (@(posedge clk_sys) disable iff (reset)
                    !rawReg[g] |-> !statusBits[g])
                    else $error("status bit set without raw bit");
            end
            else
            begin : gResv
                resv_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
                    !rawReg[g] && !maskReg[g] && !statusBits[g])
                    else $error("reserved bit became set");
            end
        end
    endgenerate

endmodule

// *** test/sic_event_src.sv ***
// Purpose: event source model for the antenna and tuner logic
// Assumes: evReq is indexed by acknowledge bit position
// Notes:   reserved positions 7, 6 and 2 are dropped here
module sic_event_src
(
    input  wire logic [7:0]      evReq,
    output sic_pkg::sic_events_t events
);
    timeunit 1ns;
    timeprecision 1ps;
    // one high cycle is one event; timeout and error or done are chosen by the bench
    assign events = {evReq[5], evReq[4], evReq[3], evReq[1], evReq[0]};
endmodule

// *** test/software_interrupt_clear_tb_top.sv ***
// Purpose: self-checking bench for the interrupt clear block
// Assumes: one clock; the master waits on waitrequest
// Notes:   reads are judged by a monitor that pops expected words
module software_interrupt_clear_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [9:0] A_RAW  = {sic_pkg::SIC_IDX_RAW, 2'b00};
    localparam logic [9:0] A_STAT = {sic_pkg::SIC_IDX_STAT, 2'b00};
    localparam logic [9:0] A_MASK = {sic_pkg::SIC_IDX_MASK, 2'b00};
    localparam logic [9:0] A_ACK  = {sic_pkg::SIC_IDX_ACK, 2'b00};
    localparam int         SRC[5] = '{5, 4, 3, 1, 0};
    logic                 clkSys;
    logic                 reset;
    logic [7:0]           evReq;
    logic [7:0]           rawM;
    logic [7:0]           maskM;
    logic [31:0]          seed;
    logic [31:0]          avsReaddata;
    logic                 avsWaitrequest;
    logic                 irqOut;
    logic [31:0]          expQ[$];
    int                   nFail;
    int                   checksDone;
    sic_pkg::sic_events_t events;
    sic_pkg::sic_req_t    avsReq;

    sic_event_src src (.evReq(evReq), .events(events));
    sic_interrupt_clear dut (.clk_sys(clkSys), .reset(reset), .events(events), .avsReq(avsReq),
        .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .irqOut(irqOut));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checksDone++;
        if (g !== e)
        begin
            nFail++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    // one request with events alongside; the model moves only after the taking edge
    task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d,
                       input logic [7:0] ev);
        avsReq <= '{address: a, read: !w, write: w, byteenable: 4'hf, writedata: {24'h0, d}};
        evReq <= ev;
        if (!w)
            expQ.push_back(a == A_RAW ? {24'h0, rawM} : a == A_STAT ? {24'h0, rawM & maskM}
                           : a == A_MASK ? {24'h0, maskM} : 32'h0);
        do @(posedge clkSys); while (avsWaitrequest !== 1'b0);
        avsReq <= '0;
        evReq <= 8'h0;
        if (w && a == A_MASK)
            maskM = d;
        rawM = (rawM & ~((w && a == A_ACK) ? d : 8'h0) | ev) & sic_pkg::SIC_IMPL_MASK;
        @(posedge clkSys);
    endtask

    // irq is looked at mid-cycle so the registered update has landed
    task automatic irqCheck();
        @(negedge clkSys);
        chk("irqOut", {31'h0, |(rawM & maskM)}, {31'h0, irqOut});
        @(posedge clkSys);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // read monitor: oldest note against the word on the bus
    always @(posedge clkSys)
    begin
        if (avsReq.read === 1'b1 && avsWaitrequest === 1'b0)
            chk("avsReaddata", expQ.pop_front(), avsReaddata);
    end

    initial
    begin
        clkSys = 1'b0;
        forever #20 clkSys = ~clkSys;
    end

    // watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clkSys);
        nFail++;
        conclude();
    end

    initial
    begin
        reset = 1'b1;
        evReq = 8'h0;
        avsReq = '0;
        rawM = 8'h0;
        maskM = 8'h0;
        seed = 32'hb6c8b2f5;
        repeat (4) @(posedge clkSys);
        reset <= 1'b0;
        foreach (SRC[i])
            bus(1'b0, {SRC[i][7:0], 2'b00} + A_RAW - 10'h14, 8'h0, 8'h0);
        $display("test reset values done");
        foreach (SRC[i])
        begin
            bus(1'b1, A_MASK, 8'h1 << SRC[i], 8'h0);
            bus(1'b0, A_RAW, 8'h0, 8'hff);
            irqCheck();
            bus(1'b1, A_ACK, 8'hc4, 8'h0);
            bus(1'b0, A_STAT, 8'h0, 8'h0);
            bus(1'b1, A_ACK, 8'h1 << SRC[i], 8'h0);
            bus(1'b0, A_RAW, 8'h0, 8'h0);
            irqCheck();
            bus(1'b1, A_ACK, 8'hff, 8'h1 << SRC[i]);
            bus(1'b0, A_STAT, 8'h0, 8'h0);
            irqCheck();
            bus(1'b1, A_ACK, 8'hff, 8'h0);
        end
        $display("test per source clear done");
        repeat (20)
        begin
            seed = lfsr(seed);
            bus(1'b1, A_MASK, seed[7:0] & sic_pkg::SIC_IMPL_MASK, 8'h0);
            bus(1'b1, A_ACK, seed[15:8], seed[23:16]);
            bus(1'b0, A_STAT, 8'h0, seed[31:24]);
            irqCheck();
        end
        $display("test random traffic done");
        conclude();
    end
endmodule
